// file: sgc_pkg.sv
// package of constants for the stop-mode peripheral clock gating block
//
// Behaviour
// - while stop mode is active the port output latch keeps the value it had when stop mode began.
// - in stop mode timer/event counter a keeps counting only when its count clock is its own external pin.
// - in stop mode timer/event counter b keeps counting only when its count clock is its own external pin.
// - in stop mode aux timer zero runs only when clocked by the timer a output while timer a is operating.
// - in stop mode aux timer one runs only when clocked by the low-speed oscillator or a listed division of it.
// - in stop mode the watch timer runs only when its count clock is the subsystem clock.
// - in stop mode the watchdog keeps running unless the option lets software stop the low-speed oscillator.
// - in stop mode the clock output keeps driving only when the subsystem clock is its source.
// - entering stop mode halts the a/d converter control whatever its clock selection.
// - in stop mode async serial zero runs only when clocked by the timer a output while timer a is operating.
// - in stop mode clocked serial ten runs only when it takes an external serial clock as a slave.
// - in stop mode the lcd timing logic runs only when its count clock is the subsystem clock.
package sgc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] SGC_ADDR_UNIT_EN = 4'h0;
  localparam logic [3:0] SGC_ADDR_CLK_SEL = 4'h4;
  localparam logic [3:0] SGC_ADDR_PORT = 4'h8;
  localparam logic [3:0] SGC_ADDR_STATUS = 4'hc;

  // ----------------------------------------------------------------
  // unit indices in enable and run vectors
  // ----------------------------------------------------------------
  localparam int SGC_NUM_UNITS = 11;
  localparam int SGC_U_TMR_A = 0;
  localparam int SGC_U_TMR_B = 1;
  localparam int SGC_U_AUX0 = 2;
  localparam int SGC_U_AUX1 = 3;
  localparam int SGC_U_WATCH = 4;
  localparam int SGC_U_WDT = 5;
  localparam int SGC_U_CLKOUT = 6;
  localparam int SGC_U_ADC = 7;
  localparam int SGC_U_SER0 = 8;
  localparam int SGC_U_CSER = 9;
  localparam int SGC_U_LCD = 10;

  // ----------------------------------------------------------------
  // clock select field positions and codes
  // ----------------------------------------------------------------
  localparam int SGC_SEL_TA_LSB = 0;         // 2 bits, timer a source
  localparam int SGC_SEL_TB_LSB = 2;         // 2 bits, timer b source
  localparam int SGC_SEL_AUX0_BIT = 4;       // 1 = timer a output
  localparam int SGC_SEL_AUX1_LSB = 5;       // 3 bits, aux timer one source
  localparam int SGC_SEL_WATCH_BIT = 8;      // 1 = subsystem clock
  localparam int SGC_SEL_CLKOUT_BIT = 9;     // 1 = subsystem clock
  localparam int SGC_SEL_SER0_BIT = 10;      // 1 = timer a output
  localparam int SGC_SEL_CSER_BIT = 11;      // 1 = external serial clock (slave)
  localparam int SGC_SEL_LCD_BIT = 12;       // 1 = subsystem clock
  localparam int SGC_SEL_WIDTH = 13;
  localparam logic [1:0] SGC_SRC_EXT_PIN = 2'h0;
  localparam logic [2:0] SGC_AUX1_LSO = 3'h5;      // low-speed osc undivided
  localparam logic [2:0] SGC_AUX1_LSO_D7 = 3'h6;   // low-speed osc / 2^7
  localparam logic [2:0] SGC_AUX1_LSO_D9 = 3'h7;   // low-speed osc / 2^9

  // ----------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------
  localparam int SGC_PORT_WIDTH = 8;
  localparam logic [SGC_NUM_UNITS-1:0] SGC_UNIT_EN_RST = 11'h020;  // watchdog runs from reset
  localparam logic [SGC_SEL_WIDTH-1:0] SGC_CLK_SEL_RST = 13'h0001;
  localparam logic [SGC_PORT_WIDTH-1:0] SGC_PORT_RST = 8'h00;
  localparam int SGC_STAT_STOP_BIT = 16;
  localparam int SGC_STAT_OPT_BIT = 17;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] SGC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SGC_RESP_SLVERR = 2'h2;

endpackage

// file: sgc_sync.sv
// two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module sgc_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);

  logic meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule // sgc_sync

// file: sgc_gate.sv
// one unit's registered run enable: enabled by software, gated in stop mode
`timescale 1ns/100ps
module sgc_gate (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic stop_i,
  input wire logic keep_i,
  output logic run_o
);

  // a unit not allowed in stop only loses its clock; its state is untouched
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_o <= 1'b0;
    end else if (ce_i) begin
      run_o <= enable_i & (~stop_i | keep_i);
    end
  end

endmodule // sgc_gate

// file: sgc_top.sv
// stop-mode peripheral clock gating with its AXI4-Lite register slave
`timescale 1ns/100ps
module sgc_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // stop request from the core, same clock
  input wire logic stop_i,
  // option byte: low-speed oscillator may be stopped by software (pin level)
  input wire logic lso_soft_stop_opt_i,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // gated outputs
  output logic sys_clk_en_o,
  output logic [sgc_pkg::SGC_PORT_WIDTH-1:0] port_o,
  output logic [sgc_pkg::SGC_NUM_UNITS-1:0] unit_run_o
);
  import sgc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [SGC_NUM_UNITS-1:0] unit_en_q;
  logic [SGC_SEL_WIDTH-1:0] clk_sel_q;
  logic [SGC_PORT_WIDTH-1:0] port_q;
  logic [SGC_NUM_UNITS-1:0] keep;
  logic opt_sync;
  logic ta_keep;
  logic aw_got_q;
  logic w_got_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] wr_mask;
  logic [31:0] rd_data;
  logic rd_hit;

  // ----------------------------------------------------------------
  // option pin crossing
  // ----------------------------------------------------------------
  sgc_sync u_opt_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(lso_soft_stop_opt_i),
    .q_o(opt_sync)
  );

  // ----------------------------------------------------------------
  // stop-mode keep conditions per unit
  // ----------------------------------------------------------------
  // timer a's own keep term is reused by its dependants in the same cycle,
  // so they never lag behind the counter they are clocked from
  assign ta_keep = (clk_sel_q[SGC_SEL_TA_LSB +: 2] == SGC_SRC_EXT_PIN);

  always_comb begin
    keep = '0;
    keep[SGC_U_TMR_A] = ta_keep;
    keep[SGC_U_TMR_B] = (clk_sel_q[SGC_SEL_TB_LSB +: 2] == SGC_SRC_EXT_PIN);
    keep[SGC_U_AUX0] = clk_sel_q[SGC_SEL_AUX0_BIT] & unit_en_q[SGC_U_TMR_A] & ta_keep;
    keep[SGC_U_AUX1] = (clk_sel_q[SGC_SEL_AUX1_LSB +: 3] == SGC_AUX1_LSO)
                       | (clk_sel_q[SGC_SEL_AUX1_LSB +: 3] == SGC_AUX1_LSO_D7)
                       | (clk_sel_q[SGC_SEL_AUX1_LSB +: 3] == SGC_AUX1_LSO_D9);
    keep[SGC_U_WATCH] = clk_sel_q[SGC_SEL_WATCH_BIT];
    keep[SGC_U_WDT] = ~opt_sync;
    keep[SGC_U_CLKOUT] = clk_sel_q[SGC_SEL_CLKOUT_BIT];
    keep[SGC_U_ADC] = 1'b0;
    keep[SGC_U_SER0] = clk_sel_q[SGC_SEL_SER0_BIT] & unit_en_q[SGC_U_TMR_A] & ta_keep;
    keep[SGC_U_CSER] = clk_sel_q[SGC_SEL_CSER_BIT];
    keep[SGC_U_LCD] = clk_sel_q[SGC_SEL_LCD_BIT];
  end

  // ----------------------------------------------------------------
  // per-unit run enables
  // ----------------------------------------------------------------
  // the status word packs run bits below the stop flag; wider vectors would collide
  if (SGC_NUM_UNITS > SGC_STAT_STOP_BIT || SGC_SEL_WIDTH > 32) begin : g_bad_width
    $error("unit or select vector too wide for its register");
  end

  genvar gi;
  generate
    for (gi = 0; gi < SGC_NUM_UNITS; gi = gi + 1) begin : g_gate
      sgc_gate u_gate (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .enable_i(unit_en_q[gi]),
        .stop_i(stop_i),
        .keep_i(keep[gi]),
        .run_o(unit_run_o[gi])
      );
    end
  endgenerate

  // system clock enable returns on the edge after stop drops; nothing is reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_clk_en_o <= 1'b1;
    end else if (ce_i) begin
      sys_clk_en_o <= ~stop_i;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // address and data are taken in either order; the write happens once both
  // are held, and no new beat is taken until the response is accepted
  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_q & ~s_axi_bvalid;
  assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_got_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_got_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (ce_i) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_q <= 1'b0;
      end
    end
  end

  // byte strobes widen into a bit mask
  always_comb begin
    wr_mask = '0;
    for (int b = 0; b < 4; b++) begin
      wr_mask[8*b +: 8] = {8{w_strb_q[b]}};
    end
  end

  assign wr_hit = (aw_addr_q == SGC_ADDR_UNIT_EN) | (aw_addr_q == SGC_ADDR_CLK_SEL)
                  | (aw_addr_q == SGC_ADDR_PORT);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SGC_RESP_OKAY;
    end else if (ce_i) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? SGC_RESP_OKAY : SGC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // unit enables and clock selects are plain state; stop never touches them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unit_en_q <= SGC_UNIT_EN_RST;
    end else if (ce_i && wr_fire && aw_addr_q == SGC_ADDR_UNIT_EN) begin
      unit_en_q <= (unit_en_q & ~wr_mask[SGC_NUM_UNITS-1:0])
                   | (w_data_q[SGC_NUM_UNITS-1:0] & wr_mask[SGC_NUM_UNITS-1:0]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_sel_q <= SGC_CLK_SEL_RST;
    end else if (ce_i && wr_fire && aw_addr_q == SGC_ADDR_CLK_SEL) begin
      clk_sel_q <= (clk_sel_q & ~wr_mask[SGC_SEL_WIDTH-1:0])
                   | (w_data_q[SGC_SEL_WIDTH-1:0] & wr_mask[SGC_SEL_WIDTH-1:0]);
    end
  end

  // the port latch ignores writes during stop; the core is halted anyway,
  // this guards against a stray bus master disturbing the pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_q <= SGC_PORT_RST;
    end else if (ce_i && wr_fire && aw_addr_q == SGC_ADDR_PORT && !stop_i) begin
      port_q <= (port_q & ~wr_mask[SGC_PORT_WIDTH-1:0])
                | (w_data_q[SGC_PORT_WIDTH-1:0] & wr_mask[SGC_PORT_WIDTH-1:0]);
    end
  end

  assign port_o = port_q;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      SGC_ADDR_UNIT_EN: rd_data[SGC_NUM_UNITS-1:0] = unit_en_q;
      SGC_ADDR_CLK_SEL: rd_data[SGC_SEL_WIDTH-1:0] = clk_sel_q;
      SGC_ADDR_PORT: rd_data[SGC_PORT_WIDTH-1:0] = port_q;
      SGC_ADDR_STATUS: begin
        rd_data[SGC_NUM_UNITS-1:0] = unit_run_o;
        rd_data[SGC_STAT_STOP_BIT] = ~sys_clk_en_o;
        rd_data[SGC_STAT_OPT_BIT] = opt_sync;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SGC_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? SGC_RESP_OKAY : SGC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_port_hold_stop: assert property (
    ce_i && stop_i && $past(stop_i) |-> $stable(port_o))
    else $error("port latch changed during stop");

  a_timer_a_gate: assert property (
    ce_i && stop_i && unit_en_q[SGC_U_TMR_A] |=> unit_run_o[SGC_U_TMR_A] == $past(ta_keep))
    else $error("timer a run disagrees with its pin source in stop");

  a_timer_b_gate: assert property (
    ce_i && stop_i && clk_sel_q[SGC_SEL_TB_LSB +: 2] != SGC_SRC_EXT_PIN |=> !unit_run_o[SGC_U_TMR_B])
    else $error("timer b ran in stop without its pin clock");

  a_aux0_follows: assert property (
    ce_i && stop_i && unit_en_q[SGC_U_AUX0] && !(unit_en_q[SGC_U_TMR_A] && ta_keep)
    |=> !unit_run_o[SGC_U_AUX0])
    else $error("aux timer zero ran while timer a was halted");

  a_aux1_source: assert property (
    ce_i && stop_i && clk_sel_q[SGC_SEL_AUX1_LSB +: 3] < SGC_AUX1_LSO |=> !unit_run_o[SGC_U_AUX1])
    else $error("aux timer one ran in stop on a stopped clock");

  a_watch_sub: assert property (
    ce_i && stop_i && !clk_sel_q[SGC_SEL_WATCH_BIT] |=> !unit_run_o[SGC_U_WATCH])
    else $error("watch timer ran in stop without subsystem clock");

  a_wdt_option: assert property (
    ce_i && stop_i && unit_en_q[SGC_U_WDT] |=> unit_run_o[SGC_U_WDT] == !$past(opt_sync))
    else $error("watchdog gating disagrees with option");

  a_clkout_sub: assert property (
    ce_i && stop_i && !clk_sel_q[SGC_SEL_CLKOUT_BIT] |=> !unit_run_o[SGC_U_CLKOUT])
    else $error("clock output drove in stop without subsystem clock");

  a_adc_halt: assert property (
    ce_i && stop_i |=> !unit_run_o[SGC_U_ADC])
    else $error("a/d converter ran in stop");

  a_ser0_follows: assert property (
    ce_i && $past(ce_i) && stop_i && $past(stop_i) && unit_run_o[SGC_U_SER0]
    |-> $past(unit_en_q[SGC_U_TMR_A] && ta_keep))
    else $error("async serial zero ran while timer a was halted");

  a_csi_slave: assert property (
    ce_i && stop_i && !clk_sel_q[SGC_SEL_CSER_BIT] |=> !unit_run_o[SGC_U_CSER])
    else $error("clocked serial ten ran in stop as master");

  a_cser_keep: assert property (
    ce_i && stop_i && unit_en_q[SGC_U_CSER] && clk_sel_q[SGC_SEL_CSER_BIT] |=> unit_run_o[SGC_U_CSER])
    else $error("clocked serial ten halted in stop as slave");

  a_timer_b_keep: assert property (
    ce_i && stop_i && unit_en_q[SGC_U_TMR_B] && clk_sel_q[SGC_SEL_TB_LSB +: 2] == SGC_SRC_EXT_PIN
    |=> unit_run_o[SGC_U_TMR_B])
    else $error("timer b halted in stop despite its pin clock");

  a_watch_keep: assert property (
    ce_i && stop_i && unit_en_q[SGC_U_WATCH] && clk_sel_q[SGC_SEL_WATCH_BIT] |=> unit_run_o[SGC_U_WATCH])
    else $error("watch timer halted in stop with subsystem clock");

  a_lcd_keep: assert property (
    ce_i && stop_i && unit_en_q[SGC_U_LCD] && clk_sel_q[SGC_SEL_LCD_BIT] |=> unit_run_o[SGC_U_LCD])
    else $error("lcd timing halted in stop with subsystem clock");

  a_port_write_stop: assert property (
    ce_i && stop_i && wr_fire |=> $stable(port_o))
    else $error("port latch took a write during stop");

  a_lcd_sub: assert property (
    ce_i && stop_i && !clk_sel_q[SGC_SEL_LCD_BIT] |=> !unit_run_o[SGC_U_LCD])
    else $error("lcd timing ran in stop without subsystem clock");

  a_resume_kept: assert property (
    ce_i && $fell(stop_i) && !wr_fire |=> sys_clk_en_o && $stable(unit_en_q) && $stable(clk_sel_q))
    else $error("state lost on leaving stop");

  // the system clock request mirrors stop one edge later, in both directions
  a_sysclk_mirror: assert property (
    ce_i |=> sys_clk_en_o == !$past(stop_i))
    else $error("system clock enable does not follow stop");

  a_run_resumes: assert property (
    ce_i && !stop_i |=> unit_run_o == $past(unit_en_q))
    else $error("run enables differ from unit enables outside stop");

endmodule // sgc_top

// file: sgc_tb.sv
// self-checking testbench for the stop-mode peripheral clock gating block
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module testbench;
  import sgc_pkg::*;

  // ----------------------------------------------------------------
  // stimulus signals and design hookup
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic stop_i = 1'b0;
  logic opt = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic sys_clk_en_o;
  logic [SGC_PORT_WIDTH-1:0] port_o;
  logic [SGC_NUM_UNITS-1:0] unit_run_o;
  int n_errors = 0;
  int cmp_count = 0;
  logic [1:0] resp;
  logic [31:0] rd;

  // 50 ns half period gives the 10 MHz clock
  always #50 clk_i = ~clk_i;

  sgc_top dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .stop_i(stop_i), .lso_soft_stop_opt_i(opt),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sys_clk_en_o(sys_clk_en_o), .port_o(port_o), .unit_run_o(unit_run_o)
  );

  // ----------------------------------------------------------------
  // verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a hung handshake counts as a mismatch and closes the run
  task automatic give_up();
    n_errors++;
    $display("mismatch at %0t: handshake wait ran out", $time);
    end_sim();
  endtask

  // readies are sampled at the falling edge, since they settle well before the taking edge
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic a_ok;
    logic w_ok;
    logic ta;
    logic tw;
    int n;
    a_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(negedge clk_i);
      ta = awready;
      tw = wready;
      n++;
      if (n > 50) give_up();
      @(posedge clk_i);
      if (!a_ok && ta) begin
        awvalid <= 1'b0;
        a_ok = 1'b1;
      end
      if (!w_ok && tw) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    bready <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      ta = bvalid;
      r = bresp;
      n++;
      if (n > 50) give_up();
      @(posedge clk_i);
    end while (!ta);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ok;
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk_i);
      ok = arready;
      n++;
      if (n > 50) give_up();
      @(posedge clk_i);
    end while (!ok);
    arvalid <= 1'b0;
    rready <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      ok = rvalid;
      d = rdata;
      r = rresp;
      n++;
      if (n > 50) give_up();
      @(posedge clk_i);
    end while (!ok);
    rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // expected run enables worked out from the stop-mode table
  // ----------------------------------------------------------------
  function automatic logic [10:0] exp_run(input logic [10:0] en, input logic [12:0] sel,
                                          input logic o, input logic stp);
    logic [10:0] k;
    logic ka;
    ka = (sel[SGC_SEL_TA_LSB +: 2] == SGC_SRC_EXT_PIN) && en[SGC_U_TMR_A];
    k[SGC_U_TMR_A] = sel[SGC_SEL_TA_LSB +: 2] == SGC_SRC_EXT_PIN;
    k[SGC_U_TMR_B] = sel[SGC_SEL_TB_LSB +: 2] == SGC_SRC_EXT_PIN;
    k[SGC_U_AUX0] = sel[SGC_SEL_AUX0_BIT] && ka;
    k[SGC_U_AUX1] = sel[SGC_SEL_AUX1_LSB +: 3] >= SGC_AUX1_LSO;
    k[SGC_U_WATCH] = sel[SGC_SEL_WATCH_BIT];
    k[SGC_U_WDT] = !o;
    k[SGC_U_CLKOUT] = sel[SGC_SEL_CLKOUT_BIT];
    k[SGC_U_ADC] = 1'b0;
    k[SGC_U_SER0] = sel[SGC_SEL_SER0_BIT] && ka;
    k[SGC_U_CSER] = sel[SGC_SEL_CSER_BIT];
    k[SGC_U_LCD] = sel[SGC_SEL_LCD_BIT];
    return stp ? (en & k) : en;
  endfunction

  // one stop episode: configure, stop, poke the port, release, check all came back
  task automatic stop_case(input logic [10:0] en, input logic [12:0] sel, input logic o,
                           input logic [7:0] p);
    axi_write(SGC_ADDR_UNIT_EN, {21'h0, en}, 4'hf, resp);
    axi_write(SGC_ADDR_CLK_SEL, {19'h0, sel}, 4'hf, resp);
    axi_write(SGC_ADDR_PORT, {24'h0, p}, 4'hf, resp);
    opt <= o;
    repeat (4) @(posedge clk_i);
    `CHK(unit_run_o, en)
    stop_i <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK(unit_run_o, exp_run(en, sel, o, 1'b1))
    `CHK(sys_clk_en_o, 1'b0)
    @(posedge clk_i);
    axi_read(SGC_ADDR_STATUS, rd, resp);
    `CHK(rd, {14'h0, o, 1'b1, 5'h0, exp_run(en, sel, o, 1'b1)})
    axi_write(SGC_ADDR_PORT, {24'h0, ~p}, 4'hf, resp);
    `CHK(resp, SGC_RESP_OKAY)
    `CHK(port_o, p)
    stop_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK(unit_run_o, en)
    `CHK(sys_clk_en_o, 1'b1)
    `CHK(port_o, p)
    @(posedge clk_i);
    axi_read(SGC_ADDR_CLK_SEL, rd, resp);
    `CHK(rd, {19'h0, sel})
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    `CHK(sys_clk_en_o, 1'b1)
    `CHK(port_o, SGC_PORT_RST)
    `CHK(unit_run_o, 11'h000)
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK(unit_run_o, SGC_UNIT_EN_RST)
    @(posedge clk_i);
    axi_read(SGC_ADDR_UNIT_EN, rd, resp);
    `CHK(rd, {21'h0, SGC_UNIT_EN_RST})
    axi_read(SGC_ADDR_CLK_SEL, rd, resp);
    `CHK(rd, {19'h0, SGC_CLK_SEL_RST})
    // only the low byte lane may take this write
    axi_write(SGC_ADDR_CLK_SEL, 32'hffff_ffff, 4'h1, resp);
    `CHK(resp, SGC_RESP_OKAY)
    axi_read(SGC_ADDR_CLK_SEL, rd, resp);
    `CHK(rd, 32'h0000_00ff)
    `CHK(resp, SGC_RESP_OKAY)
    // an unaligned offset hits no register: refused, nothing written, reads zero
    axi_write(4'h6, 32'hffff_ffff, 4'hf, resp);
    `CHK(resp, SGC_RESP_SLVERR)
    axi_read(4'h2, rd, resp);
    `CHK(rd, 32'h0000_0000)
    `CHK(resp, SGC_RESP_SLVERR)
    axi_read(SGC_ADDR_CLK_SEL, rd, resp);
    `CHK(rd, 32'h0000_00ff)
    // rows chosen so each unit is both kept and halted somewhere, except the a/d converter, which is halted in every stop
    stop_case(11'h7ff, 13'h0001, 1'b0, 8'h3c);
    stop_case(11'h7ff, 13'h1fb0, 1'b0, 8'h5a);
    stop_case(11'h7ff, 13'h1fb0, 1'b1, 8'ha7);
    stop_case(11'h7fe, 13'h1fb0, 1'b0, 8'h01);
    stop_case(11'h7ff, 13'h00c0, 1'b1, 8'hff);
    stop_case(11'h7ff, 13'h00e5, 1'b0, 8'h80);
    stop_case(11'h7ff, 13'h0491, 1'b0, 8'h00);
    stop_case(11'h5ff, 13'h0a0e, 1'b0, 8'h96);
    // with the clock enable low nothing may move, even a stop request
    ce_i <= 1'b0;
    stop_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(unit_run_o, 11'h5ff)
    `CHK(sys_clk_en_o, 1'b1)
    @(posedge clk_i);
    ce_i <= 1'b1;
    stop_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    end_sim();
  end
endmodule // testbench
